// [sca_pkg.sv]
package sca_pkg;

    // ==========================================================
    // block placement and register offsets
    localparam logic [31:0] SCA_BASE_ADDR     = 32'hE000ED00;
    localparam int          SCA_BLOCK_BITS    = 8;
    localparam logic [7:0]  SCA_OFF_IDENTITY  = 8'h00;
    localparam logic [7:0]  SCA_OFF_PRIO1     = 8'h18;
    localparam logic [7:0]  SCA_OFF_PRIO2     = 8'h1C;
    localparam logic [7:0]  SCA_OFF_PRIO3     = 8'h20;
    localparam logic [7:0]  SCA_OFF_FAULT_ST  = 8'h28;
    localparam logic [7:0]  SCA_OFF_MM_ADDR   = 8'h34;
    localparam logic [7:0]  SCA_OFF_BUS_ADDR  = 8'h38;

    // ==========================================================
    // field layout and reset values
    localparam int          SCA_MM_VALID_BIT  = 7;
    localparam int          SCA_BUS_VALID_BIT = 15;
    localparam logic [31:0] SCA_RST_WORD      = 32'h00000000;

    // ==========================================================
    // access sizes
    typedef enum logic [1:0] {
        SCA_SZ_BYTE = 2'h0,
        SCA_SZ_HALF = 2'h1,
        SCA_SZ_WORD = 2'h2
    } sca_size_e;

    typedef struct packed {
        logic        write;
        sca_size_e   size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } sca_req_s;

    typedef struct packed {
        logic [31:0] rdata;
        logic        err;
    } sca_rsp_s;

endpackage : sca_pkg

// [sca_access_rules.sv]
// Function
// - fault status and the three priority registers take byte, aligned half and aligned word.
// - unaligned accesses to any register are refused, never carried out.
// - a newer fault may overwrite the fault address registers at any time.
// - the block decodes at base 0xE000ED00, offsets relative to it.
// - with its valid flag set, each fault address register holds the faulting address, unless software has written it since.
`timescale 1ns/1ps

module sca_access_rules
    import sca_pkg::*;
#(
    // identity fields: arbitrary values
    parameter logic [7:0]  IMPLEMENTER = 8'h5A,
    parameter logic [3:0]  VARIANT     = 4'h0,
    parameter logic [3:0]  CONSTANT    = 4'hF,
    parameter logic [11:0] PART_NO     = 12'h123,
    parameter logic [3:0]  REVISION    = 4'h1
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        req_valid,
    input  wire sca_req_s    req,
    output logic             rsp_valid,
    output sca_rsp_s         rsp,
    input  wire logic        mm_fault,
    input  wire logic [31:0] mm_fault_addr,
    input  wire logic        bus_fault,
    input  wire logic [31:0] bus_fault_addr,
    input  wire logic [31:0] fault_flags_set,
    output logic [95:0]      handler_priority
);

    // ==========================================================
    // helpers
    function automatic logic is_aligned(sca_size_e sz, logic [1:0] a);
        case (sz)
            SCA_SZ_BYTE: is_aligned = 1'b1;
            SCA_SZ_HALF: is_aligned = ~a[0];
            SCA_SZ_WORD: is_aligned = (a == 2'h0);
            default:     is_aligned = 1'b0;
        endcase
    endfunction : is_aligned

    function automatic logic [31:0] lane_mask(sca_size_e sz, logic [1:0] a);
        case (sz)
            SCA_SZ_BYTE: lane_mask = 32'h000000FF << {a, 3'h0};
            SCA_SZ_HALF: lane_mask = 32'h0000FFFF << {a[1], 4'h0};
            default:     lane_mask = 32'hFFFFFFFF;
        endcase
    endfunction : lane_mask

    localparam logic [31:0] ID_WORD = {IMPLEMENTER, VARIANT, CONSTANT, PART_NO, REVISION};

    // ==========================================================
    // decode
    logic [7:0]  off;
    logic        hit, narrow_ok, word_reg, mapped, ok, wr;
    logic [31:0] mask, wmasked;
    logic        is_prio, is_fst, is_mm, is_bus, is_id;

    assign off = req.addr[7:0];
    assign hit = req_valid
              && (req.addr[31:SCA_BLOCK_BITS] == SCA_BASE_ADDR[31:SCA_BLOCK_BITS]);
    assign is_id   = ({off[7:2], 2'h0} == SCA_OFF_IDENTITY);
    assign is_prio = ({off[7:2], 2'h0} == SCA_OFF_PRIO1)
                  || ({off[7:2], 2'h0} == SCA_OFF_PRIO2)
                  || ({off[7:2], 2'h0} == SCA_OFF_PRIO3);
    assign is_fst  = ({off[7:2], 2'h0} == SCA_OFF_FAULT_ST);
    assign is_mm   = ({off[7:2], 2'h0} == SCA_OFF_MM_ADDR);
    assign is_bus  = ({off[7:2], 2'h0} == SCA_OFF_BUS_ADDR);
    assign narrow_ok = is_prio || is_fst;
    assign word_reg  = is_id || is_mm || is_bus;
    assign mapped    = narrow_ok || word_reg;
    // narrow sizes on fault status and priorities
    // other registers only as aligned words; unaligned refused
    assign ok = mapped && is_aligned(req.size, off[1:0])
             && (narrow_ok || (req.size == SCA_SZ_WORD));
    assign wr      = hit && ok && req.write;
    assign mask    = lane_mask(req.size, off[1:0]);
    assign wmasked = req.wdata & mask;

    // ==========================================================
    // handler priorities
    logic [31:0] prio_q [3];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                prio_q[i] <= SCA_RST_WORD;
            end
        end else if (wr && is_prio) begin
            for (int i = 0; i < 3; i++) begin
                if ({off[7:2], 2'h0} == SCA_OFF_PRIO1 + 8'(4 * i)) begin
                    prio_q[i] <= (prio_q[i] & ~mask) | wmasked;
                end
            end
        end
    end
    assign handler_priority = {prio_q[2], prio_q[1], prio_q[0]};

    // ==========================================================
    // fault status, write one to clear
    logic [31:0] fst_q, fst_set, fst_clr;
    always_comb begin
        fst_set = fault_flags_set;
        fst_set[SCA_MM_VALID_BIT]  = mm_fault;
        fst_set[SCA_BUS_VALID_BIT] = bus_fault;
        fst_clr = (wr && is_fst) ? wmasked : 32'h00000000;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fst_q <= SCA_RST_WORD;
        end else begin
            // set beats a clear in the same cycle
            fst_q <= (fst_q & ~fst_clr) | fst_set;
        end
    end

    // ==========================================================
    // fault addresses
    logic [31:0] mm_addr_q, bus_addr_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mm_addr_q <= SCA_RST_WORD;
        end else if (mm_fault) begin
            mm_addr_q <= mm_fault_addr;
        end else if (wr && is_mm) begin
            mm_addr_q <= req.wdata;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_addr_q <= SCA_RST_WORD;
        end else if (bus_fault) begin
            bus_addr_q <= bus_fault_addr;
        end else if (wr && is_bus) begin
            bus_addr_q <= req.wdata;
        end
    end

    // ==========================================================
    // response, one cycle after the request
    logic [31:0] rd;
    always_comb begin
        rd = 32'h00000000;
        // identity is fixed and never written
        if (is_id) rd = ID_WORD;
        for (int i = 0; i < 3; i++) begin
            if ({off[7:2], 2'h0} == SCA_OFF_PRIO1 + 8'(4 * i)) rd = prio_q[i];
        end
        if (is_fst) rd = fst_q;
        if (is_mm)  rd = mm_addr_q;
        if (is_bus) rd = bus_addr_q;
        // lanes outside the access read as zero
        rd = rd & mask;
    end

    logic     rsp_valid_q;
    sca_rsp_s rsp_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_q <= 1'b0;
            rsp_q       <= '0;
        end else begin
            rsp_valid_q <= hit;
            if (hit) begin
                // refused access: error, no data, no effect
                rsp_q.err   <= ~ok;
                rsp_q.rdata <= (ok && !req.write) ? rd : 32'h00000000;
            end
        end
    end
    assign rsp_valid = rsp_valid_q;
    assign rsp       = rsp_q;

    // ==========================================================
    // checks
    a_rsp_follows_hit: assert property (@(posedge clk) disable iff (!rst_n)
        hit |=> rsp_valid) else $error("no answer after request");
    a_no_spurious_rsp: assert property (@(posedge clk) disable iff (!rst_n)
        !hit |=> !rsp_valid) else $error("answer without request");
    a_word_only_regs: assert property (@(posedge clk) disable iff (!rst_n)
        hit && word_reg && req.size != SCA_SZ_WORD |=> rsp.err) else $error("narrow not refused");
    a_narrow_accepted: assert property (@(posedge clk) disable iff (!rst_n)
        hit && narrow_ok && is_aligned(req.size, off[1:0]) |=> !rsp.err)
        else $error("narrow access refused");
    a_unaligned_refused: assert property (@(posedge clk) disable iff (!rst_n)
        hit && !is_aligned(req.size, off[1:0]) |=> rsp.err && rsp.rdata == 32'h0)
        else $error("unaligned accepted");
    a_base_decode: assert property (@(posedge clk) disable iff (!rst_n)
        req_valid && req.addr[31:SCA_BLOCK_BITS] != SCA_BASE_ADDR[31:SCA_BLOCK_BITS]
        |=> !rsp_valid) else $error("outside decoded");
    a_mm_capture: assert property (@(posedge clk) disable iff (!rst_n)
        mm_fault |=> mm_addr_q == $past(mm_fault_addr) && fst_q[SCA_MM_VALID_BIT])
        else $error("memmanage address not captured");
    a_bus_capture: assert property (@(posedge clk) disable iff (!rst_n)
        bus_fault |=> bus_addr_q == $past(bus_fault_addr) && fst_q[SCA_BUS_VALID_BIT])
        else $error("newer bus fault lost");
    a_set_beats_clear: assert property (@(posedge clk) disable iff (!rst_n)
        mm_fault && wr && is_fst |=> fst_q[SCA_MM_VALID_BIT]) else $error("valid flag lost");
    a_identity_fixed: assert property (@(posedge clk) disable iff (!rst_n)
        hit && is_id && ok && !req.write |=> rsp.rdata == ID_WORD) else $error("identity wrong");

    c_byte_prio: cover property (@(posedge clk) disable iff (!rst_n)
        wr && is_prio && req.size == SCA_SZ_BYTE);
    c_unaligned: cover property (@(posedge clk) disable iff (!rst_n)
        hit && !ok && mapped);
    c_fault_preempt: cover property (@(posedge clk) disable iff (!rst_n)
        mm_fault ##[1:4] mm_fault);
    c_clear_valid: cover property (@(posedge clk) disable iff (!rst_n)
        wr && is_fst && wmasked[SCA_BUS_VALID_BIT]);

endmodule : sca_access_rules

// [sca_cpu_model.sv]
`timescale 1ns/1ps

module sca_cpu_model
    import sca_pkg::*;
(
    input  wire logic     clk,
    output logic          req_valid,
    output sca_req_s      req,
    input  wire logic     rsp_valid,
    input  wire sca_rsp_s rsp
);
    initial begin
        req_valid = 1'b0;
        req       = '0;
    end

    // caller picks size
    // released fields get scrambled so stale values cannot pass
    task automatic access(input sca_req_s r, output logic got, output sca_rsp_s a);
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req       = r;
        @(posedge clk);
        #1;
        got       = rsp_valid;
        a         = rsp;
        req_valid = 1'b0;
        req       = ~r;
    endtask : access
endmodule : sca_cpu_model

// [testbench.sv]
`timescale 1ns/1ps

module testbench
    import sca_pkg::*;
;
    typedef struct {sca_req_s r; logic e; logic [31:0] d;} sca_tb_row_s;
    logic clk, rst_n, req_valid, rsp_valid, mm_fault, bus_fault;
    logic [31:0] mm_fault_addr, bus_fault_addr, fault_flags_set;
    logic [95:0] handler_priority;
    sca_req_s    req;
    sca_rsp_s    rsp;
    sca_tb_row_s rows[15];
    int          mismatches, n_compared, cycles;

    sca_access_rules sca_access_rules_i (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .mm_fault(mm_fault),
        .mm_fault_addr(mm_fault_addr), .bus_fault(bus_fault), .bus_fault_addr(bus_fault_addr),
        .fault_flags_set(fault_flags_set), .handler_priority(handler_priority));
    sca_cpu_model sca_cpu_model_i (.clk(clk), .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid), .rsp(rsp));

    function automatic sca_req_s mk(logic w, sca_size_e s, logic [7:0] o, logic [31:0] d);
        return '{w, s, SCA_BASE_ADDR | {24'h0, o}, d};
    endfunction : mk

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test

    task automatic check_val(input string n, input logic [95:0] e, input logic [95:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : check_val

    task automatic do_acc(input sca_req_s r, input logic e, input logic [31:0] d);
        logic     g;
        sca_rsp_s a;
        sca_cpu_model_i.access(r, g, a);
        check_val("rsp_valid", 96'h1, {95'h0, g});
        check_val("err", {95'h0, e}, {95'h0, a.err});
        check_val("rdata", {64'h0, d}, {64'h0, a.rdata});
    endtask : do_acc

    task automatic pulse(input logic bus, input logic [31:0] a, input logic [31:0] f);
        @(posedge clk);
        #1;
        {mm_fault, bus_fault, fault_flags_set} = {~bus, bus, f};
        if (bus) bus_fault_addr = a;
        else mm_fault_addr = a;
        @(posedge clk);
        #1;
        {mm_fault, bus_fault, fault_flags_set} = {1'b0, 1'b0, 32'h0};
        {mm_fault_addr, bus_fault_addr} = ~{mm_fault_addr, bus_fault_addr};
    endtask : pulse

    // ==========================================================
    // clock, reset and timeout
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        {rst_n, mm_fault, bus_fault} = 3'b000;
        {mm_fault_addr, bus_fault_addr, fault_flags_set} = '0;
        rows = '{
            '{mk(1'b0, SCA_SZ_WORD, 8'h00, 32'h0), 1'b0, 32'h5A0F1231},
            '{mk(1'b1, SCA_SZ_WORD, 8'h00, 32'hFFFFFFFF), 1'b0, 32'h0},
            '{mk(1'b0, SCA_SZ_WORD, 8'h00, 32'h0), 1'b0, 32'h5A0F1231},
            '{mk(1'b0, SCA_SZ_HALF, 8'h00, 32'h0), 1'b1, 32'h0},
            '{mk(1'b1, SCA_SZ_BYTE, 8'h19, 32'h0000AB00), 1'b0, 32'h0},
            '{mk(1'b1, SCA_SZ_HALF, 8'h1A, 32'h12340000), 1'b0, 32'h0},
            '{mk(1'b1, SCA_SZ_HALF, 8'h19, 32'hFFFFFFFF), 1'b1, 32'h0},
            '{mk(1'b1, SCA_SZ_WORD, 8'h1A, 32'hFFFFFFFF), 1'b1, 32'h0},
            '{mk(1'b0, SCA_SZ_WORD, 8'h18, 32'h0), 1'b0, 32'h1234AB00},
            '{mk(1'b0, SCA_SZ_BYTE, 8'h1B, 32'h0), 1'b0, 32'h12000000},
            '{mk(1'b1, SCA_SZ_WORD, 8'h34, 32'h11223344), 1'b0, 32'h0},
            '{mk(1'b0, SCA_SZ_HALF, 8'h34, 32'h0), 1'b1, 32'h0},
            '{mk(1'b0, SCA_SZ_WORD, 8'h34, 32'h0), 1'b0, 32'h11223344},
            '{mk(1'b0, sca_size_e'(2'h3), 8'h28, 32'h0), 1'b1, 32'h0},
            '{mk(1'b1, SCA_SZ_WORD, 8'h20, 32'hAABBCCDD), 1'b0, 32'h0}};
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        foreach (rows[i]) do_acc(rows[i].r, rows[i].e, rows[i].d);
        check_val("prio", {32'hAABBCCDD, 32'h0, 32'h1234AB00}, handler_priority);
        // address read first, then the flag
        pulse(1'b0, 32'h20001234, 32'h0);
        do_acc(mk(1'b0, SCA_SZ_WORD, 8'h34, 32'h0), 1'b0, 32'h20001234);
        do_acc(mk(1'b0, SCA_SZ_WORD, 8'h28, 32'h0), 1'b0, 32'h00000080);
        pulse(1'b1, 32'h40000010, 32'h0);
        pulse(1'b1, 32'h40000020, 32'h0);
        do_acc(mk(1'b0, SCA_SZ_WORD, 8'h38, 32'h0), 1'b0, 32'h40000020);
        do_acc(mk(1'b0, SCA_SZ_WORD, 8'h28, 32'h0), 1'b0, 32'h00008080);
        do_acc(mk(1'b1, SCA_SZ_BYTE, 8'h29, 32'h00008000), 1'b0, 32'h0);
        pulse(1'b1, 32'h40000030, 32'h00010000);
        do_acc(mk(1'b0, SCA_SZ_HALF, 8'h2A, 32'h0), 1'b0, 32'h00010000);
        do_acc(mk(1'b0, SCA_SZ_BYTE, 8'h28, 32'h0), 1'b0, 32'h00000080);
        // fault and clear of its flag in one cycle: the set must win
        fork
            pulse(1'b0, 32'h20005678, 32'h0);
            do_acc(mk(1'b1, SCA_SZ_BYTE, 8'h28, 32'h00000080), 1'b0, 32'h0);
        join
        do_acc(mk(1'b0, SCA_SZ_WORD, 8'h28, 32'h0), 1'b0, 32'h00018080);
        do_acc(mk(1'b0, SCA_SZ_WORD, 8'h34, 32'h0), 1'b0, 32'h20005678);
        begin
            logic     g;
            sca_rsp_s a;
            sca_cpu_model_i.access(
                sca_req_s'{1'b0, SCA_SZ_WORD, SCA_BASE_ADDR + 32'h00000100, 32'h0}, g, a);
            check_val("outside rsp_valid", 96'h0, {95'h0, g});
        end
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        @(posedge clk);
        #1;
        check_val("prio after reset", 96'h0, handler_priority);
        rst_n = 1'b1;
        do_acc(mk(1'b0, SCA_SZ_WORD, 8'h18, 32'h0), 1'b0, 32'h0);
        finish_test();
    end
endmodule : testbench
